/* sdil_pkg.sv */
// Shared constants and types for the serial converter input latch
package sdil_pkg;

   // Frame layout
   localparam int          SDIL_WORD_W   = 16;
   localparam int          SDIL_CNT_W    = 5;
   localparam logic [4:0]  SDIL_LAST_BIT = 5'h10;
   localparam logic [4:0]  SDIL_CNT_ZERO = 5'h00;
   localparam logic [4:0]  SDIL_CNT_ONE  = 5'h01;
   localparam logic [15:0] SDIL_MIDCODE  = 16'h0000;

   // Clock rate and link timing
   localparam int SDIL_CLK_MHZ      = 100;
   localparam int SDIL_LEAD_NS      = 20;
   localparam int SDIL_IDLE_NS      = 20;
   localparam int SDIL_WAIT_NS      = 100;
   localparam int SDIL_POWERUP_US   = 100;
   localparam int SDIL_HALF_NS      = 40;
   localparam int SDIL_LEAD_CYC     = (SDIL_LEAD_NS * SDIL_CLK_MHZ + 999) / 1000;
   localparam int SDIL_IDLE_CYC     = (SDIL_IDLE_NS * SDIL_CLK_MHZ + 999) / 1000;
   localparam int SDIL_WAIT_CYC     = (SDIL_WAIT_NS * SDIL_CLK_MHZ + 999) / 1000;
   localparam int SDIL_HALF_CYC     = (SDIL_HALF_NS * SDIL_CLK_MHZ + 999) / 1000;
   localparam int SDIL_POWERUP_CYC  = SDIL_POWERUP_US * SDIL_CLK_MHZ;
   localparam int SDIL_TMR_W        = 16;

   // Controller states
   typedef enum logic [4:0] {
      SDIL_ST_POWERUP = 5'h01,
      SDIL_ST_IDLE    = 5'h02,
      SDIL_ST_LEAD    = 5'h04,
      SDIL_ST_SHIFT   = 5'h08,
      SDIL_ST_GAP     = 5'h10
   } sdil_state_t;

endpackage

/* sdil_link_if.sv */
// Three-wire serial link between controller and converter front end
`timescale 1ns/1ps
interface sdil_link_if;
   logic select_n;
   logic bit_clk;
   logic serial_in_pin;

   modport controller (output select_n, output bit_clk, output serial_in_pin);
   modport converter  (input select_n, input bit_clk, input serial_in_pin);
endinterface // sdil_link_if

/* sdil_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sdil_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Level in and out
   input  wire logic din,
   output logic      dout
);
   logic meta;
   logic next_meta;
   logic next_dout;

   // Next values
   always_comb begin
      next_meta = din;
      next_dout = meta;
   end

   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule // sdil_sync

/* sdil_converter.sv */
// Converter end: serial shift register and output latch
// How it works
// - Data input ignored while select high
// - Bit clock edges ignored while select high
// - Select active low; data accepted only low
// - Clear low at 16th clock loads midcode
// - Clear high at 16th clock loads shifted word
// - Sixteen-bit two's complement word, MSB first
// - Controller waits 20 ns before first clock
// - Controller keeps select high 20 ns between
// - Controller waits 100 ns after 16th fall
// - Controller waits 100 us after power up
// - Rising clock shifts data in, MSB first
// - Clocks after update ignored until select falls
// - Select high before update discards partial word
// - Clear never disturbs shifting; midcode held
`timescale 1ns/1ps
module sdil_converter (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // Serial link
   sdil_link_if.converter                     link,
   // Clear input, active low
   input  wire logic                          zero_out_n,
   // Converter latch
   output logic      [sdil_pkg::SDIL_WORD_W-1:0] dac_code,
   output logic                               dac_update
);
   import sdil_pkg::*;

   // Limits of this front end:
   // - every link pin passes two flip-flops, so a link half period
   //   must last three ref_clk cycles or more
   // - clock, data and select share one synchroniser depth, so their
   //   order on the pins is kept inside
   // - the latch moves two to three cycles after the 16th clock fall

   // Synchronised pin levels
   logic                   sel_n_s;
   logic                   clk_s;
   logic                   din_s;
   logic                   clr_n_s;
   // Edge history of the synchronised pins
   logic                   clk_d;
   logic                   sel_d;
   logic                   next_clk_d;
   logic                   next_sel_d;
   // Shift register, bit count and clear sample
   logic [SDIL_WORD_W-1:0] shreg;
   logic [SDIL_CNT_W-1:0]  cnt;
   logic                   clr_seen;
   logic [SDIL_WORD_W-1:0] next_shreg;
   logic [SDIL_CNT_W-1:0]  next_cnt;
   logic                   next_clr_seen;
   // Latch next values
   logic [SDIL_WORD_W-1:0] next_dac_code;
   logic                   next_dac_update;
   // Decoded events of this cycle
   logic                   rise;
   logic                   fall;
   logic                   sel_fall;
   logic                   take_bit;
   logic                   last_bit;
   logic                   load_latch;
   logic                   clear_now;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Select line
   sdil_sync u_sync_sel (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (link.select_n),
      .dout    (sel_n_s)
   );

   // Bit clock
   sdil_sync u_sync_clk (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (link.bit_clk),
      .dout    (clk_s)
   );

   // Serial data
   sdil_sync u_sync_din (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (link.serial_in_pin),
      .dout    (din_s)
   );

   // Clear input
   sdil_sync u_sync_clr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (zero_out_n),
      .dout    (clr_n_s)
   );

   // ----------------------------------------
   // Frame events
   // ----------------------------------------
   // Edges and the actions they trigger this cycle.
   // Rise and fall never meet in one cycle, so a bit and a
   // latch load are mutually exclusive.
   always_comb begin
      rise       = clk_s & ~clk_d;
      fall       = ~clk_s & clk_d;
      sel_fall   = ~sel_n_s & sel_d;
      take_bit   = ~sel_n_s & ~sel_fall & rise & (cnt < SDIL_LAST_BIT);
      last_bit   = take_bit & (cnt == SDIL_LAST_BIT - SDIL_CNT_ONE);
      load_latch = ~sel_n_s & ~sel_fall & fall & (cnt == SDIL_LAST_BIT);
      clear_now  = clr_seen | ~clr_n_s;
   end

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   // Previous synchronised levels
   always_comb begin
      next_clk_d = clk_s;
      next_sel_d = sel_n_s;
   end

   // Reset levels match the synchronisers, so no false edge after reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clk_d <= 1'b0;
         sel_d <= 1'b0;
      end else begin
         clk_d <= next_clk_d;
         sel_d <= next_sel_d;
      end
   end

   // ----------------------------------------
   // Shift register and bit count
   // ----------------------------------------
   // Count runs 0 to 16 while bits arrive, then parks at 17 so that
   // extra clocks do nothing until select rises and falls again.
   // A partial word stays in the register but never reaches the latch.
   always_comb begin
      next_shreg    = shreg;
      next_cnt      = cnt;
      next_clr_seen = clr_seen;
      if (sel_n_s || sel_fall) begin
         next_cnt = SDIL_CNT_ZERO;
      end else if (take_bit) begin
         next_shreg = {shreg[SDIL_WORD_W-2:0], din_s};
         next_cnt   = cnt + SDIL_CNT_ONE;
         if (last_bit) begin
            next_clr_seen = ~clr_n_s;
         end
      end else if (load_latch) begin
         next_cnt = SDIL_LAST_BIT + SDIL_CNT_ONE;
      end
   end

   // Shift state registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shreg    <= SDIL_MIDCODE;
         cnt      <= SDIL_CNT_ZERO;
         clr_seen <= 1'b0;
      end else begin
         shreg    <= next_shreg;
         cnt      <= next_cnt;
         clr_seen <= next_clr_seen;
      end
   end

   // ----------------------------------------
   // Converter latch
   // ----------------------------------------
   // Clear low at the 16th rise or fall wins over the shifted word
   always_comb begin
      next_dac_code   = dac_code;
      next_dac_update = 1'b0;
      if (load_latch) begin
         next_dac_update = 1'b1;
         if (clear_now) begin
            next_dac_code = SDIL_MIDCODE;
         end else begin
            next_dac_code = shreg;
         end
      end
   end

   // Latch registers, outputs straight from here
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dac_code   <= SDIL_MIDCODE;
         dac_update <= 1'b0;
      end else begin
         dac_code   <= next_dac_code;
         dac_update <= next_dac_update;
      end
   end
endmodule // sdil_converter

/* sdil_controller.sv */
// Controller end: sends one 16-bit word per request
`timescale 1ns/1ps
module sdil_controller
#(
   parameter int POWERUP_CYC = sdil_pkg::SDIL_POWERUP_CYC
) (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // Serial link
   sdil_link_if.controller                    link,
   // User request
   input  wire logic                          send_valid,
   input  wire logic [sdil_pkg::SDIL_WORD_W-1:0] send_word,
   output logic                               send_ready
);
   import sdil_pkg::*;

   sdil_state_t            state;
   sdil_state_t            next_state;
   logic [SDIL_TMR_W-1:0]  tmr;
   logic [SDIL_TMR_W-1:0]  next_tmr;
   logic [SDIL_CNT_W-1:0]  bits;
   logic [SDIL_CNT_W-1:0]  next_bits;
   logic [SDIL_WORD_W-1:0] word;
   logic [SDIL_WORD_W-1:0] next_word;
   logic                   sel_n;
   logic                   next_sel_n;
   logic                   sclk;
   logic                   next_sclk;
   logic                   sdo;
   logic                   next_sdo;
   logic                   next_ready;

   assign link.select_n      = sel_n;
   assign link.bit_clk       = sclk;
   assign link.serial_in_pin = sdo;

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_tmr   = tmr;
      next_bits  = bits;
      next_word  = word;
      next_sel_n = sel_n;
      next_sclk  = sclk;
      next_sdo   = sdo;
      next_ready = 1'b0;
      if (tmr != '0) next_tmr = tmr - 16'h0001;
      unique case (state)
         SDIL_ST_POWERUP: begin
            if (tmr == '0) begin
               next_state = SDIL_ST_IDLE;
               next_ready = 1'b1;
            end
         end
         SDIL_ST_IDLE: begin
            next_ready = ~send_valid;
            if (send_valid && send_ready) begin
               next_word  = {send_word[SDIL_WORD_W-2:0], 1'b0};
               next_sdo   = send_word[SDIL_WORD_W-1];
               next_sel_n = 1'b0;
               next_bits  = SDIL_CNT_ZERO;
               next_tmr   = SDIL_TMR_W'(SDIL_LEAD_CYC + SDIL_HALF_CYC);
               next_state = SDIL_ST_LEAD;
            end
         end
         SDIL_ST_LEAD: begin
            if (tmr == '0) begin
               next_sclk  = 1'b1;
               next_bits  = SDIL_CNT_ONE;
               next_tmr   = SDIL_TMR_W'(SDIL_HALF_CYC);
               next_state = SDIL_ST_SHIFT;
            end
         end
         SDIL_ST_SHIFT: begin
            if (tmr == '0) begin
               next_tmr = SDIL_TMR_W'(SDIL_HALF_CYC);
               if (sclk) begin
                  next_sclk = 1'b0;
                  if (bits == SDIL_LAST_BIT) begin
                     next_tmr   = SDIL_TMR_W'(SDIL_HALF_CYC);
                     next_state = SDIL_ST_GAP;
                  end else begin
                     next_sdo  = word[SDIL_WORD_W-1];
                     next_word = {word[SDIL_WORD_W-2:0], 1'b0};
                  end
               end else begin
                  next_sclk = 1'b1;
                  next_bits = bits + SDIL_CNT_ONE;
               end
            end
         end
         SDIL_ST_GAP: begin
            if (!sel_n) begin
               // Hold select past the far end's latch update first
               if (tmr == '0) begin
                  next_sel_n = 1'b1;
                  next_tmr   = SDIL_TMR_W'(SDIL_WAIT_CYC + SDIL_IDLE_CYC);
               end
            end else if (tmr == '0) begin
               next_state = SDIL_ST_IDLE;
               next_ready = 1'b1;
            end
         end
      endcase
   end

   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state      <= SDIL_ST_POWERUP;
         tmr        <= SDIL_TMR_W'(POWERUP_CYC);
         bits       <= SDIL_CNT_ZERO;
         word       <= SDIL_MIDCODE;
         sel_n      <= 1'b1;
         sclk       <= 1'b0;
         sdo        <= 1'b0;
         send_ready <= 1'b0;
      end else begin
         state      <= next_state;
         tmr        <= next_tmr;
         bits       <= next_bits;
         word       <= next_word;
         sel_n      <= next_sel_n;
         sclk       <= next_sclk;
         sdo        <= next_sdo;
         send_ready <= next_ready;
      end
   end
endmodule // sdil_controller

/* sdil_link_monitor.sv */
// Checker for the serial link between controller and converter
`timescale 1ns/1ps
module sdil_link_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Link and latch
   input wire logic select_n,
   input wire logic bit_clk,
   input wire logic serial_in_pin,
   input wire logic dac_update
);
   logic [4:0] rises;
   logic [4:0] next_rises;
   logic       sel_q;
   logic       clk_q;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // ----------------
   // Frame bit counter
   // ----------------
   // Count rising bit clocks since select fell
   always_comb begin
      next_rises = rises;
      if (sel_q && !select_n) next_rises = 5'h00;
      else if (!select_n && bit_clk && !clk_q && rises != 5'h1F) next_rises = rises + 5'h01;
   end

   // Register counter and edge history
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rises <= 5'h00;
         sel_q <= 1'b1;
         clk_q <= 1'b0;
      end else begin
         rises <= next_rises;
         sel_q <= select_n;
         clk_q <= bit_clk;
      end
   end

   // ----------------
   // Assertions
   // ----------------
   a_lead_time: assert property ($fell(select_n) |-> !bit_clk [*3])
      else $error("bit clock rose too soon after select fell");
   a_gap_after: assert property ($rose(select_n) |-> select_n [*6])
      else $error("select low again too soon");
   a_clk_still: assert property (select_n |-> !bit_clk)
      else $error("bit clock moves while select high");
   a_half_period: assert property ($rose(bit_clk) |-> bit_clk [*5] ##1 !bit_clk)
      else $error("bit clock high time wrong");
   a_low_time: assert property ($fell(bit_clk) |-> !bit_clk [*5])
      else $error("bit clock low time too short");
   a_data_hold: assert property (bit_clk |-> $stable(serial_in_pin))
      else $error("data changed while bit clock high");
   a_word_length: assert property ($rose(select_n) |-> rises == 5'h10)
      else $error("frame not sixteen bits");
   a_update_count: assert property (dac_update |-> rises == 5'h10)
      else $error("latch update without sixteen bits");
   a_update_time: assert property ($fell(bit_clk) && rises == 5'h10 |-> ##[3:6] dac_update)
      else $error("latch update late after last bit");

   // Main scenarios reached
   c_frame: cover property ($fell(select_n));
   c_update: cover property (dac_update);
   c_end: cover property ($rose(select_n));
endmodule // sdil_link_monitor

/* serial_dac_input_latch_test.sv */
// Self-checking bench for both ends of the serial converter link
`timescale 1ns/1ps
module serial_dac_input_latch_test;
   import sdil_pkg::*;
   logic        ref_clk, rst, send_valid, send_ready, zero_out_n, zero_out_n_b;
   logic        dac_update, dac_update_b;
   logic [15:0] send_word, dac_code, dac_code_b, wire_word;
   int          n_fail, samples_checked;
   int          n_upd_b = 0;

   // ----------------
   // Design and checker
   // ----------------
   sdil_link_if link ();
   sdil_link_if link_b ();
   sdil_controller #(.POWERUP_CYC(20)) sdil_controller_i (.ref_clk(ref_clk), .rst(rst),
      .link(link.controller), .send_valid(send_valid), .send_word(send_word),
      .send_ready(send_ready));
   sdil_converter sdil_converter_i (.ref_clk(ref_clk), .rst(rst), .link(link.converter),
      .zero_out_n(zero_out_n), .dac_code(dac_code), .dac_update(dac_update));
   // Second converter faced by the bench itself
   sdil_converter sdil_converter_i2 (.ref_clk(ref_clk), .rst(rst), .link(link_b.converter),
      .zero_out_n(zero_out_n_b), .dac_code(dac_code_b), .dac_update(dac_update_b));
   sdil_link_monitor sdil_link_monitor_i (.ref_clk(ref_clk), .rst(rst),
      .select_n(link.select_n), .bit_clk(link.bit_clk),
      .serial_in_pin(link.serial_in_pin), .dac_update(dac_update));

   // Clock and observers of the wire and second latch
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge link.bit_clk) if (!link.select_n) wire_word <= {wire_word[14:0], link.serial_in_pin};
   always @(posedge ref_clk) if (dac_update_b === 1'b1) n_upd_b <= n_upd_b + 1;

   // ----------------
   // Shared tasks
   // ----------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (n_fail == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One frame through the controller, then judge the latch and the wire
   task automatic send(input logic [15:0] w, input logic clr, input logic [15:0] exp);
      int i;
      @(negedge ref_clk);
      zero_out_n = clr;
      send_word = w;
      send_valid = 1'b1;
      for (i = 0; i < 2000 && send_ready !== 1'b1; i++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("ready after take", 16'h0000, {15'h0000, send_ready});
      send_valid = 1'b0;
      for (i = 0; i < 400 && dac_update !== 1'b1; i++) @(negedge ref_clk);
      chk("update pulse", 16'h0001, {15'h0000, dac_update});
      chk("latch code", exp, dac_code);
      chk("wire word", w, wire_word);
   endtask

   // Bench drives bits on the second link, 80 ns bit clock
   task automatic b_bits(input logic [15:0] w, input int n);
      for (int k = 15; k > 15 - n; k--) begin
         link_b.serial_in_pin = w[k];
         repeat (4) @(negedge ref_clk);
         link_b.bit_clk = 1'b1;
         repeat (4) @(negedge ref_clk);
         link_b.bit_clk = 1'b0;
      end
      repeat (2) @(negedge ref_clk);
      link_b.serial_in_pin = ~link_b.serial_in_pin;
      repeat (20) @(negedge ref_clk);
   endtask

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_codes();
      send(16'h7FFF, 1'b1, 16'h7FFF);
      send(16'h8000, 1'b1, 16'h8000);
      send(16'h4000, 1'b1, 16'h4000);
      send(16'hBFFF, 1'b1, 16'hBFFF);
   endtask

   task automatic t_clear();
      send(16'h1234, 1'b0, 16'h0000);
      send(16'h5A5A, 1'b1, 16'h5A5A);
   endtask

   task automatic t_extra();
      link_b.select_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      b_bits(16'hC3A5, 16);
      b_bits(16'hFFFF, 16);
      link_b.select_n = 1'b1;
      repeat (20) @(negedge ref_clk);
      chk("extra clocks code", 16'hC3A5, dac_code_b);
      chk("extra clocks updates", 16'h0001, 16'(n_upd_b));
   endtask

   task automatic t_abort();
      link_b.select_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      b_bits(16'h0FF0, 15);
      link_b.select_n = 1'b1;
      repeat (20) @(negedge ref_clk);
      chk("aborted code", 16'hC3A5, dac_code_b);
      chk("aborted updates", 16'h0001, 16'(n_upd_b));
   endtask

   task automatic t_ignore();
      b_bits(16'h0000, 16);
      b_bits(16'hFFFF, 16);
      chk("deselected code", 16'hC3A5, dac_code_b);
      chk("deselected updates", 16'h0001, 16'(n_upd_b));
   endtask

   // ----------------
   // Main sequence and watchdog
   // ----------------
   initial begin
      rst = 1'b1;
      send_valid = 1'b0;
      send_word = 16'h0000;
      zero_out_n = 1'b1;
      zero_out_n_b = 1'b1;
      link_b.select_n = 1'b1;
      link_b.bit_clk = 1'b0;
      link_b.serial_in_pin = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      t_codes();
      t_clear();
      t_extra();
      t_abort();
      t_ignore();
      wrap_up();
   end

   // Tests need about 20 us; cut a hang well beyond that
   initial begin
      #100us;
      n_fail++;
      wrap_up();
   end
endmodule // serial_dac_input_latch_test
